// [swd_pkg.sv]
// Package of constants for the supervisory window/time-out watchdog.
// Assumes a 10 MHz core clock and a 1 ms timebase tick derived inside the block.
package swd_pkg;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 10000000;
    localparam int TICK_US = 1000;
    localparam int TICK_CYCLES = (CLK_HZ / 1000000) * TICK_US;
    localparam int PERIOD_MIN_MS = 16;
    localparam int PERIOD_MAX_MS = 1024;
    localparam int PERIOD_DEF_MS = 256;
    localparam int CLOSED_PCT = 50;
    localparam int RESET_LOW_MS = 5;
    // ------------------------------------------------------------
    // Setting encodings
    // ------------------------------------------------------------
    localparam logic [2:0] TIMING_DEF = 3'h4;
    localparam logic [2:0] TIMING_MAX = 3'h6;
    localparam logic [2:0] MODE_NORMAL = 3'h0;
    localparam logic [2:0] MODE_STOP = 3'h1;
    localparam logic [2:0] MODE_REFLASH = 3'h2;
    localparam logic [2:0] MODE_READ = 3'h3;
    localparam logic [2:0] MODE_SLEEP = 3'h4;
    localparam logic [2:0] MODE_DEVEL = 3'h5;
    localparam logic [1:0] UNLOCK_KEY0 = 2'h1;
    localparam logic [1:0] UNLOCK_KEY1 = 2'h2;
    localparam logic [1:0] CAUSE_WDOG = 2'h1;
    localparam logic [2:0] LIMP_WDOG = 3'h1;
endpackage

// [swd_watchdog.sv]
// Watchdog core: service decode at frame end, window timing, failure handling.
// Assumes an SPI front end presents decoded command fields that are stable from the rise of
// the select line until MCLK has sampled it high; select and frame fields come from pins.
module swd_watchdog #(
    parameter int TICK_CYCLES = swd_pkg::TICK_CYCLES,
    parameter bit FAILSAFE_CFG = 1'b0
) (
    // Clock, reset, enable
    input wire logic MCLK,
    input wire logic RSTN,
    input wire logic CLK_EN,
    // Frame pins (asynchronous to MCLK)
    input wire logic SELECT_LINE_LOW_ACTIVE_N,
    input wire logic FRAME_WRITE,
    input wire logic SERVICE_TOGGLE_BIT,
    input wire logic [2:0] FRAME_MODE,
    input wire logic FRAME_CFG_WRITE,
    input wire logic FRAME_WINDOW_MODE,
    input wire logic [2:0] FRAME_TIMING,
    input wire logic [1:0] FRAME_UNLOCK_KEY,
    input wire logic FRAME_WAKE_READ,
    // System events
    input wire logic CYCLIC_WAKE,
    // Status and outputs
    output logic RESET_OUTPUT_PIN,
    output logic FAILSAFE,
    output logic WDOG_FAIL_IRQ,
    output logic BAD_SETTING_FLAG,
    output logic [1:0] RESTART_CAUSE,
    output logic [2:0] LIMP_HOME_CAUSE,
    output logic WDOG_ACTIVE,
    output logic WINDOW_OPEN
);
    initial begin
        if (TICK_CYCLES < 1 || TICK_CYCLES > 65535) $error("TICK_CYCLES out of range");
    end

    typedef enum logic [1:0] {SWD_NORMAL, SWD_LOWPWR, SWD_RESTART, SWD_FAILSAFE} swd_state_t;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [13:0] sync1, sync2;
    logic sel_q;
    always_ff @(posedge MCLK) begin
        if (!RSTN) begin
            sync1 <= 14'h3fff;
            sync2 <= 14'h3fff;
            sel_q <= 1'b1;
        end else if (CLK_EN) begin
            sync1 <= {SELECT_LINE_LOW_ACTIVE_N, FRAME_WRITE, SERVICE_TOGGLE_BIT, FRAME_MODE, FRAME_CFG_WRITE,
                      FRAME_WINDOW_MODE, FRAME_TIMING, FRAME_UNLOCK_KEY, FRAME_WAKE_READ};
            sync2 <= sync1;
            sel_q <= sync2[13];
        end
    end
    logic f_wr, f_bit, f_cfg, f_win, f_wake;
    logic [2:0] f_mode, f_tim;
    logic [1:0] f_key;
    assign {f_wr, f_bit, f_mode, f_cfg, f_win, f_tim, f_key, f_wake} = sync2[12:0];
    logic frame_end;
    assign frame_end = CLK_EN && sync2[13] && !sel_q;

    // ------------------------------------------------------------
    // Timebase and period counter
    // ------------------------------------------------------------
    logic [15:0] pre;
    logic tick;
    assign tick = CLK_EN && (pre == 16'(TICK_CYCLES - 1));
    always_ff @(posedge MCLK) begin
        if (!RSTN || (CLK_EN && tick)) begin
            pre <= 16'h0000;
        end else if (CLK_EN) begin
            pre <= pre + 16'h0001;
        end
    end

    swd_state_t state;
    logic win_mode;
    logic [2:0] timing;
    logic last_bit;
    logic disabled;
    logic key_ok;
    logic wake_pend;
    logic [10:0] ms;
    logic [10:0] period;
    logic [10:0] rst_cnt;
    assign period = 11'(swd_pkg::PERIOD_MIN_MS) << timing;
    logic [10:0] closed_len;
    assign closed_len = 11'((period * swd_pkg::CLOSED_PCT) / 100);
    assign WINDOW_OPEN = !win_mode || (ms >= closed_len);
    assign WDOG_ACTIVE = (state == SWD_NORMAL || state == SWD_LOWPWR) && !disabled;

    // ------------------------------------------------------------
    // Service decode
    // ------------------------------------------------------------
    logic svc_mode, toggled, trig_ok, trig_bad, expired, fail, new_ok, cfg_req, stop_exit, wake_miss;
    assign svc_mode = f_mode == swd_pkg::MODE_NORMAL || f_mode == swd_pkg::MODE_STOP ||
                      f_mode == swd_pkg::MODE_REFLASH || f_mode == swd_pkg::MODE_READ;
    assign toggled = frame_end && f_wr && svc_mode && (f_bit != last_bit);
    assign trig_ok = WDOG_ACTIVE && toggled && WINDOW_OPEN;
    assign trig_bad = WDOG_ACTIVE && toggled && !WINDOW_OPEN;
    assign expired = WDOG_ACTIVE && tick && (ms + 11'h001 >= period);
    assign wake_miss = CLK_EN && CYCLIC_WAKE && wake_pend && WDOG_ACTIVE && state == SWD_LOWPWR;
    assign fail = trig_bad || expired || wake_miss;
    assign stop_exit = frame_end && f_wr && state == SWD_LOWPWR && f_mode == swd_pkg::MODE_NORMAL;
    assign cfg_req = frame_end && f_wr && f_cfg && state == SWD_NORMAL;
    assign new_ok = f_tim <= swd_pkg::TIMING_MAX;

    // ------------------------------------------------------------
    // Period counter and settings
    // ------------------------------------------------------------
    always_ff @(posedge MCLK) begin
        if (!RSTN) begin
            ms <= 11'h000;
        end else if (CLK_EN) begin
            if (trig_ok || stop_exit || fail) begin
                ms <= 11'h000;
            end else if (tick && WDOG_ACTIVE) begin
                ms <= ms + 11'h001;
            end
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RSTN) begin
            win_mode <= 1'b0;
            timing <= swd_pkg::TIMING_DEF;
        end else if (CLK_EN) begin
            if (fail && !devel_on) begin
                win_mode <= 1'b0;
                timing <= swd_pkg::TIMING_DEF;
            end else if (cfg_req && trig_ok && new_ok) begin
                win_mode <= f_win;
                timing <= f_tim;
            end
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RSTN) begin
            last_bit <= 1'b0;
        end else if (CLK_EN) begin
            if (fail) begin
                last_bit <= 1'b0;
            end else if (trig_ok || stop_exit) begin
                last_bit <= f_bit;
            end
        end
    end

    // ------------------------------------------------------------
    // Inhibit unlock: key0 then key1 in consecutive write frames
    // ------------------------------------------------------------
    logic lowpwr_cmd;
    assign lowpwr_cmd = f_mode == swd_pkg::MODE_STOP || f_mode == swd_pkg::MODE_REFLASH;
    always_ff @(posedge MCLK) begin
        if (!RSTN) begin
            disabled <= 1'b0;
            key_ok <= 1'b0;
        end else if (CLK_EN && frame_end && f_wr) begin
            key_ok <= 1'b0;
            if (stop_exit) begin
                disabled <= 1'b0;
            end else if (f_key == swd_pkg::UNLOCK_KEY0 && lowpwr_cmd) begin
                key_ok <= 1'b1;
            end else if (f_key == swd_pkg::UNLOCK_KEY1 && key_ok && lowpwr_cmd && state == SWD_LOWPWR) begin
                disabled <= 1'b1;
            end
        end
    end

    logic bad_unlock;
    assign bad_unlock = frame_end && f_wr && f_key != 2'h0 &&
                        !(f_key == swd_pkg::UNLOCK_KEY0 && lowpwr_cmd) &&
                        !(f_key == swd_pkg::UNLOCK_KEY1 && key_ok && lowpwr_cmd && state == SWD_LOWPWR);
    always_ff @(posedge MCLK) begin
        if (!RSTN) begin
            BAD_SETTING_FLAG <= 1'b0;
        end else if (CLK_EN) begin
            if ((cfg_req && trig_ok && !new_ok) || bad_unlock) begin
                BAD_SETTING_FLAG <= 1'b1;
            end else if (frame_end && f_mode == swd_pkg::MODE_READ && !f_wr) begin
                BAD_SETTING_FLAG <= 1'b0;
            end
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RSTN) begin
            wake_pend <= 1'b0;
        end else if (CLK_EN) begin
            if (CYCLIC_WAKE) begin
                wake_pend <= 1'b1;
            end else if (frame_end && f_wake) begin
                wake_pend <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Device state and reset output
    // ------------------------------------------------------------
    logic devel;
    assign devel = f_mode == swd_pkg::MODE_DEVEL;
    logic devel_on;
    always_ff @(posedge MCLK) begin
        if (!RSTN) begin
            devel_on <= 1'b0;
        end else if (CLK_EN && frame_end && f_wr && devel) begin
            devel_on <= 1'b1;
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RSTN) begin
            state <= SWD_NORMAL;
            rst_cnt <= 11'h000;
        end else if (CLK_EN) begin
            case (state)
                SWD_NORMAL: begin
                    if (fail && !devel_on) begin
                        state <= (FAILSAFE_CFG && !wake_miss) ? SWD_FAILSAFE : SWD_RESTART;
                        rst_cnt <= 11'h000;
                    end else if (frame_end && f_wr && lowpwr_cmd) begin
                        state <= SWD_LOWPWR;
                    end
                end
                SWD_LOWPWR: begin
                    if (fail && !devel_on) begin
                        state <= (FAILSAFE_CFG && !wake_miss) ? SWD_FAILSAFE : SWD_RESTART;
                        rst_cnt <= 11'h000;
                    end else if (stop_exit) begin
                        state <= SWD_NORMAL;
                    end
                end
                SWD_RESTART: begin
                    if (tick) begin
                        rst_cnt <= rst_cnt + 11'h001;
                    end
                    if (tick && rst_cnt == 11'(swd_pkg::RESET_LOW_MS - 1)) begin
                        state <= SWD_NORMAL;
                    end
                end
                default: begin
                    state <= SWD_FAILSAFE;
                end
            endcase
        end
    end
    assign RESET_OUTPUT_PIN = !(state == SWD_RESTART || state == SWD_FAILSAFE);
    assign FAILSAFE = state == SWD_FAILSAFE;

    always_ff @(posedge MCLK) begin
        if (!RSTN) begin
            RESTART_CAUSE <= 2'h0;
            LIMP_HOME_CAUSE <= 3'h0;
            WDOG_FAIL_IRQ <= 1'b0;
        end else if (CLK_EN) begin
            WDOG_FAIL_IRQ <= fail && devel_on;
            if (fail) begin
                RESTART_CAUSE <= swd_pkg::CAUSE_WDOG;
                LIMP_HOME_CAUSE <= swd_pkg::LIMP_WDOG;
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_closed_toggle_fails: assert property (@(posedge MCLK) disable iff (!RSTN)
        (trig_bad && !devel_on && state == SWD_NORMAL) |=> !RESET_OUTPUT_PIN)
        else $error("Closed window toggle did not reset");
    chk_service_restarts: assert property (@(posedge MCLK) disable iff (!RSTN)
        trig_ok |=> ms == 11'h000)
        else $error("Service did not restart period");
    chk_timeout_open: assert property (@(posedge MCLK) disable iff (!RSTN)
        (toggled && WDOG_ACTIVE && !win_mode && !expired && !wake_miss) |=> (ms == 11'h000 && RESET_OUTPUT_PIN))
        else $error("Time-out mode refused a toggle");
    chk_fail_cause: assert property (@(posedge MCLK) disable iff (!RSTN)
        (fail && CLK_EN) |=> RESTART_CAUSE == swd_pkg::CAUSE_WDOG)
        else $error("Failure cause not recorded");
    chk_devel_no_reset: assert property (@(posedge MCLK) disable iff (!RSTN)
        (fail && devel_on && state == SWD_NORMAL) |=> RESET_OUTPUT_PIN && WDOG_FAIL_IRQ)
        else $error("Development mode reset on failure");
    chk_default_after: assert property (@(posedge MCLK) disable iff (!RSTN)
        (state == SWD_RESTART) |-> (timing == swd_pkg::TIMING_DEF && !win_mode))
        else $error("Default setting not restored");
    chk_bad_keep_old: assert property (@(posedge MCLK) disable iff (!RSTN)
        (cfg_req && trig_ok && !new_ok) |=> timing == $past(timing))
        else $error("Invalid setting was applied");
    chk_stop_no_cfg: assert property (@(posedge MCLK) disable iff (!RSTN)
        (state == SWD_LOWPWR && !fail) |=> timing == $past(timing))
        else $error("Setting changed in low power");
endmodule

// [swd_host.sv]
// Host model: drives one command frame at a time on the watchdog frame pins.
// Assumes the bench calls send from a single process; pins move on MCLK falling edges.
module swd_host (
    // Clock
    input wire logic MCLK,
    // Frame pins
    output logic sel_n,
    output logic wr,
    output logic tog,
    output logic [2:0] mode,
    output logic cfgw,
    output logic winm,
    output logic [2:0] tim,
    output logic [1:0] key,
    output logic wrd
);
    timeunit 1ns;
    timeprecision 1ns;
    // ------------------------------
    // Frame driver
    // ------------------------------
    initial begin
        sel_n = 1'b1;
        {wr, tog, mode, cfgw, winm, tim, key, wrd} = 13'h0;
    end
    // Fields held 4 cycles past select rise, then scrambled: stale values must not look valid
    task automatic send(input logic w, input logic t, input logic [2:0] m, input logic c, input logic n,
                        input logic [2:0] p, input logic [1:0] k, input logic r);
        @(negedge MCLK);
        {wr, tog, mode, cfgw, winm, tim, key, wrd} = {w, t, m, c, n, p, k, r};
        sel_n = 1'b0;
        repeat (8) @(negedge MCLK);
        sel_n = 1'b1; // Frame ends here
        repeat (4) @(negedge MCLK);
        {wr, tog, mode, cfgw, winm, tim, key, wrd} = ~{w, t, m, c, n, p, k, r};
    endtask
endmodule

// [sbc_window_timeout_watchdog_tb.sv]
// Self-checking bench for the watchdog core with a host model on the frame pins.
// Assumes a 10-cycle tick; event notes are matched by a monitor sampling at falling edges.
module sbc_window_timeout_watchdog_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int TK = 10;
    localparam int PD = swd_pkg::PERIOD_DEF_MS * TK;
    localparam int TOL = 2 * TK + 8;
    typedef struct {int kind; int at;} swd_note_t;
    logic MCLK, RSTN, CYCLIC_WAKE, sel_n, wr, tog, cfgw, winm, wrd, rst_out, fs, irq, bad, act, wopen;
    logic prev_rst, prev_bad, b, rst_fs, fs_fs;
    logic [2:0] mode, tim, limp;
    logic [1:0] key, cause;
    logic [15:0] lfsr;
    int cyc, n_errors, n_checks, t_srv, n;
    swd_note_t notes[$];

    swd_watchdog #(.TICK_CYCLES(TK), .FAILSAFE_CFG(1'b0)) dut (.MCLK(MCLK), .RSTN(RSTN), .CLK_EN(1'b1),
        .SELECT_LINE_LOW_ACTIVE_N(sel_n), .FRAME_WRITE(wr), .SERVICE_TOGGLE_BIT(tog), .FRAME_MODE(mode),
        .FRAME_CFG_WRITE(cfgw), .FRAME_WINDOW_MODE(winm), .FRAME_TIMING(tim), .FRAME_UNLOCK_KEY(key),
        .FRAME_WAKE_READ(wrd), .CYCLIC_WAKE(CYCLIC_WAKE), .RESET_OUTPUT_PIN(rst_out), .FAILSAFE(fs),
        .WDOG_FAIL_IRQ(irq), .BAD_SETTING_FLAG(bad), .RESTART_CAUSE(cause), .LIMP_HOME_CAUSE(limp),
        .WDOG_ACTIVE(act), .WINDOW_OPEN(wopen));
    swd_watchdog #(.TICK_CYCLES(TK), .FAILSAFE_CFG(1'b1)) dut_fs (.MCLK(MCLK), .RSTN(RSTN), .CLK_EN(1'b1),
        .SELECT_LINE_LOW_ACTIVE_N(sel_n), .FRAME_WRITE(wr), .SERVICE_TOGGLE_BIT(tog), .FRAME_MODE(mode),
        .FRAME_CFG_WRITE(cfgw), .FRAME_WINDOW_MODE(winm), .FRAME_TIMING(tim), .FRAME_UNLOCK_KEY(key),
        .FRAME_WAKE_READ(wrd), .CYCLIC_WAKE(CYCLIC_WAKE), .RESET_OUTPUT_PIN(rst_fs), .FAILSAFE(fs_fs),
        .WDOG_FAIL_IRQ(), .BAD_SETTING_FLAG(), .RESTART_CAUSE(), .LIMP_HOME_CAUSE(),
        .WDOG_ACTIVE(), .WINDOW_OPEN());
    swd_host host (.MCLK(MCLK), .sel_n(sel_n), .wr(wr), .tog(tog), .mode(mode), .cfgw(cfgw),
        .winm(winm), .tim(tim), .key(key), .wrd(wrd));

    initial begin
        MCLK = 1'b0;
        forever #50 MCLK = ~MCLK;
    end
    // ------------------------------
    // Checking and monitor
    // ------------------------------
    task automatic wrap_up();
        if (notes.size() != 0) n_errors++;
        if (n_errors == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [2:0] got, input logic [2:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Tick phase is unknown, so event times match within a tolerance
    task automatic chk_ev(input int kind);
        swd_note_t x;
        x = '{-1, -1};
        if (notes.size() != 0) x = notes.pop_front();
        n_checks++;
        if (x.kind != kind || cyc < x.at - TOL || cyc > x.at + TOL) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, {kind, cyc}, {x.kind, x.at});
        end
    endtask
    always @(negedge MCLK) begin
        cyc <= cyc + 1;
        prev_rst <= rst_out;
        prev_bad <= bad;
        if (RSTN === 1'b1 && prev_rst === 1'b1 && rst_out === 1'b0) chk_ev(0);
        if (RSTN === 1'b1 && irq === 1'b1) chk_ev(1);
        if (RSTN === 1'b1 && prev_bad === 1'b0 && bad === 1'b1) chk_ev(2);
        if (cyc > 30000) begin
            n_errors++;
            wrap_up();
        end
    end
    // ------------------------------
    // Stimulus helpers
    // ------------------------------
    function automatic int rnd(input int base, input int span);
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        return base + int'(lfsr) % span;
    endfunction
    // Toggling write whose frame ends gap cycles after the previous service; ev notes an event there
    task automatic svc(input int gap, input logic [2:0] m, input logic c, input logic w, input logic [2:0] t,
                       input int ev);
        repeat (t_srv + gap - cyc - 13) @(negedge MCLK);
        if (ev >= 0) notes.push_back('{ev, t_srv + gap + 3});
        b = ~b;
        host.send(1'b1, b, m, c, w, t, 2'h0, 1'b0);
        t_srv = cyc;
    endtask
    task automatic pulse_wake();
        @(negedge MCLK) CYCLIC_WAKE = 1'b1;
        @(negedge MCLK) CYCLIC_WAKE = 1'b0;
    endtask
    // Waits out a restart, checking its reset length, then restarts from defaults
    task automatic ride_restart(input int lim);
        n = 0;
        while (rst_out !== 1'b0 && n < lim) begin @(negedge MCLK); n++; end
        n = 0;
        while (rst_out !== 1'b1 && n < 200) begin @(negedge MCLK); n++; end
        chk(n >= 4 * TK && n <= 6 * TK, 1'b1); // Restart length
        chk({fs, act, wopen}, 3'h3); // Default time-out, no fail-safe
        t_srv = cyc;
        b = 1'b0;
    endtask
    initial begin
        RSTN = 1'b0;
        CYCLIC_WAKE = 1'b0;
        b = 1'b0;
        lfsr = 16'hcdcf;
        {cyc, n_errors, n_checks, t_srv} = '0;
        {prev_rst, prev_bad} = 2'h2;
        repeat (2) @(negedge MCLK);
        RSTN = 1'b1;
        t_srv = cyc;
        @(negedge MCLK);
        chk({bad, act, wopen}, 3'h3);
        chk(rst_out, 1'b1);
        svc(rnd(1800, 400), swd_pkg::MODE_NORMAL, 0, 0, 0, -1); // First toggle writes one
        svc(rnd(1800, 400), swd_pkg::MODE_READ, 0, 0, 0, -1); // Read-only refresh
        notes.push_back('{0, t_srv + PD}); // Expiry one period after the last service
        repeat (1500) @(negedge MCLK);
        host.send(1'b1, b, swd_pkg::MODE_NORMAL, 0, 0, 0, 2'h0, 1'b0); // Repeat value is no trigger
        ride_restart(PD);
        chk(cause, swd_pkg::CAUSE_WDOG);
        chk(limp, swd_pkg::LIMP_WDOG);
        chk({rst_fs, fs_fs}, 3'h1); // Fail-safe variant holds reset low
        svc(rnd(200, 400), swd_pkg::MODE_NORMAL, 1, 1, 3'h0, -1); // Window of 16 ms on a trigger
        repeat (60) @(negedge MCLK);
        chk(wopen, 1'b0); // Closed half
        repeat (40) @(negedge MCLK);
        chk(wopen, 1'b1); // Open half
        for (int i = 0; i < 3; i++) svc(rnd(110, 30), 3'(i % 4), 0, 0, 0, -1);
        svc(rnd(110, 30), swd_pkg::MODE_NORMAL, 0, 0, 0, -1); // Reflash left for Normal
        svc(rnd(110, 30), swd_pkg::MODE_NORMAL, 1, 1, 3'h7, 2); // Invalid timing flagged
        svc(rnd(110, 30), swd_pkg::MODE_NORMAL, 0, 0, 0, -1); // Old period still runs
        host.send(1'b0, b, swd_pkg::MODE_READ, 0, 0, 0, 2'h0, 1'b0);
        chk(bad, 1'b0);
        svc(rnd(110, 30), swd_pkg::MODE_STOP, 0, 0, 0, -1); // Stop entry refreshes
        notes.push_back('{2, cyc + 12});
        host.send(1'b1, b, swd_pkg::MODE_STOP, 0, 0, 0, swd_pkg::UNLOCK_KEY1, 1'b0); // Out of order
        chk(act, 1'b1);
        host.send(1'b1, b, swd_pkg::MODE_STOP, 0, 0, 0, swd_pkg::UNLOCK_KEY0, 1'b0);
        host.send(1'b1, b, swd_pkg::MODE_STOP, 0, 0, 0, swd_pkg::UNLOCK_KEY1, 1'b0);
        chk(act, 1'b0);
        repeat (300) @(negedge MCLK);
        b = 1'b0;
        host.send(1'b1, b, swd_pkg::MODE_NORMAL, 1, 1, 3'h6, 2'h0, 1'b0); // Change refused
        t_srv = cyc;
        chk({act, wopen}, 2'h2); // Back on, closed first
        svc(rnd(110, 30), swd_pkg::MODE_NORMAL, 0, 0, 0, -1); // One after zero, old period
        svc(rnd(110, 30), swd_pkg::MODE_STOP, 0, 0, 0, -1);
        pulse_wake();
        host.send(1'b0, b, swd_pkg::MODE_READ, 0, 0, 0, 2'h0, 1'b1);
        pulse_wake();
        notes.push_back('{0, cyc + 2});
        pulse_wake(); // Wake without a read restarts
        ride_restart(50);
        svc(rnd(200, 100), swd_pkg::MODE_NORMAL, 1, 1, 3'h0, -1);
        svc(20, swd_pkg::MODE_NORMAL, 0, 0, 0, 0); // Toggle in closed window fails
        ride_restart(100);
        host.send(1'b1, b, swd_pkg::MODE_DEVEL, 0, 0, 0, 2'h0, 1'b0);
        notes.push_back('{1, t_srv + PD});
        repeat (PD + TOL) @(negedge MCLK);
        chk(rst_out, 1'b1); // No reset in development mode
        wrap_up();
    end
endmodule
